// ===== design/gqs_cmd_engine.v
// Command engine for pin value queries and volatile run-time settings over AXI4-Lite
`include "gqs_defines.vh"

// Summary of operation
// - Code 0x51 in byte 0 requests pin values; bytes 1-63 ignored.
// - Query reply echoes code in byte 0 and 0x00 success in byte 1.
// - Reply bytes 2,4,6,8 hold 0xee if not GPIO, else pin level.
// - Reply bytes 3,5,7,9 hold 0xef if not GPIO, else 0 out/1 in.
// - Code 0x60 loads run-time settings; byte 1 is ignored.
// - Settings live in volatile flops only, kept until next power-up reset.
// - Byte 2 bit 7 set loads bits 4-0; clear keeps the divider.
// - Byte 2 bits 4-3 choose duty 0/25/50/75 percent; bits 6-5 ignored.
// - Byte 2 bits 2-0 give the new divider, applied when loading.
// - Byte 3 bit 7 set loads reference from bits 2-0; else unchanged.
// - Byte 3 bits 2-1 pick reference level: off, 1.024, 2.048, 4.096 V.
// - Byte 3 bit 0 picks reference source: 1 internal module, 0 supply.
// - Byte 4 bit 7 set loads DAC value from bits 4-0; else kept.
module gqs_cmd_engine #(
    parameter [2:0] DEF_CLK_DIV   = 3'h0,   // Power-up clock divider
    parameter [1:0] DEF_CLK_DUTY  = 2'h0,   // Power-up duty cycle code
    parameter [1:0] DEF_REF_LEVEL = 2'h0,   // Power-up reference level
    parameter       DEF_REF_SRC   = 1'b0,   // Power-up reference source
    parameter [4:0] DEF_DAC_VALUE = 5'h00   // Power-up DAC value
) (
    input  wire        i_clk,            // 200 MHz clock
    input  wire        i_rst,            // Synchronous reset, high
    input  wire        i_ce,             // Clock enable, freezes state when low
    input  wire [7:0]  i_s_axi_awaddr,   // Write address
    input  wire        i_s_axi_awvalid,  // Write address valid
    output wire        o_s_axi_awready,  // Write address ready
    input  wire [31:0] i_s_axi_wdata,    // Write data
    input  wire [3:0]  i_s_axi_wstrb,    // Write byte strobes
    input  wire        i_s_axi_wvalid,   // Write data valid
    output wire        o_s_axi_wready,   // Write data ready
    output wire [1:0]  o_s_axi_bresp,    // Write response
    output wire        o_s_axi_bvalid,   // Write response valid
    input  wire        i_s_axi_bready,   // Write response ready
    input  wire [7:0]  i_s_axi_araddr,   // Read address
    input  wire        i_s_axi_arvalid,  // Read address valid
    output wire        o_s_axi_arready,  // Read address ready
    output wire [31:0] o_s_axi_rdata,    // Read data
    output wire [1:0]  o_s_axi_rresp,    // Read response
    output wire        o_s_axi_rvalid,   // Read data valid
    input  wire        i_s_axi_rready,   // Read data ready
    input  wire [3:0]  i_pin_level,      // Logic level, bit 0 = general_pin_zero
    input  wire [3:0]  i_pin_is_gpio,    // Pin assigned to GPIO use
    input  wire [3:0]  i_pin_is_input,   // GPIO direction, 1 = input
    output wire [2:0]  o_clk_div,        // Clock-output divider
    output wire [1:0]  o_clk_duty,       // Clock-output duty cycle code
    output wire [1:0]  o_int_ref_level,  // internal_reference_module level
    output wire        o_dac_ref_int,    // DAC reference from internal module
    output wire [4:0]  o_dac_value,      // DAC output value
    output wire        o_busy            // Command executing
);

    // One-hot engine states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;

    // Report buffer: 64 command bytes as 16 little-endian words
    reg  [31:0] cmd_mem [0:15];

    // AXI write channel state
    reg         awready_reg;
    reg         wready_reg;
    reg         aw_full_reg;
    reg         w_full_reg;
    reg  [7:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         bvalid_reg;
    reg  [1:0]  bresp_reg;

    // AXI read channel state
    reg         arready_reg;
    reg         rvalid_reg;
    reg  [31:0] rdata_reg;
    reg  [1:0]  rresp_reg;

    // Engine state, reply and settings
    reg  [1:0]  state_reg;
    reg         go_reg;
    reg         done_reg;
    reg         bad_reg;
    reg  [7:0]  last_code_reg;
    reg  [79:0] reply_reg;
    reg  [2:0]  clk_div_reg;
    reg  [1:0]  clk_duty_reg;
    reg  [1:0]  ref_level_reg;
    reg         ref_src_reg;
    reg  [4:0]  dac_value_reg;

    // Combinational helpers
    wire        aw_hs;
    wire        w_hs;
    wire        ar_hs;
    wire        do_write;
    wire        wr_cmd;
    wire        wr_ctrl;
    wire        wr_status;
    wire        wr_ro;
    wire        clr_done;
    wire        clr_bad;
    wire [7:0]  cmd_code;
    wire [7:0]  set_clk;
    wire [7:0]  set_ref;
    wire [7:0]  set_dac;
    wire [63:0] pin_bytes;
    wire [31:0] status_word;
    wire [31:0] settings_word;
    wire [31:0] pins_word;
    reg  [31:0] rd_data;
    reg  [1:0]  rd_resp;
    integer     k;

    assign aw_hs = i_s_axi_awvalid & awready_reg;
    assign w_hs  = i_s_axi_wvalid & wready_reg;
    assign ar_hs = i_s_axi_arvalid & arready_reg;

    // A write is performed once address and data are both held, in either order
    assign do_write  = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_cmd    = (aw_addr_reg[7:6] == `GQS_REGION_CMD);
    assign wr_ctrl   = ({aw_addr_reg[7:2], 2'b00} == `GQS_OFS_CTRL);
    assign wr_status = ({aw_addr_reg[7:2], 2'b00} == `GQS_OFS_STATUS);
    assign wr_ro     = (aw_addr_reg[7:6] == `GQS_REGION_REPLY)
                     | ({aw_addr_reg[7:2], 2'b00} == `GQS_OFS_SETTINGS)
                     | ({aw_addr_reg[7:2], 2'b00} == `GQS_OFS_PINS);

    // Write-one-to-clear of the sticky status flags
    assign clr_done = do_write & wr_status & w_strb_reg[0] & w_data_reg[`GQS_ST_DONE_BIT];
    assign clr_bad  = do_write & wr_status & w_strb_reg[0] & w_data_reg[`GQS_ST_BAD_BIT];

    // Report bytes the engine decodes; byte 1 and bytes past 4 are never looked at
    assign cmd_code = cmd_mem[0][7:0];
    assign set_clk  = cmd_mem[0][23:16];
    assign set_ref  = cmd_mem[0][31:24];
    assign set_dac  = cmd_mem[1][7:0];

    // Per-pin reply bytes: level at even index, direction at odd index
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            assign pin_bytes[16*gi +: 8]     = i_pin_is_gpio[gi] ?
                {7'h00, i_pin_level[gi]} : `GQS_NOT_GPIO_LEVEL;
            assign pin_bytes[16*gi + 8 +: 8] = i_pin_is_gpio[gi] ?
                {7'h00, i_pin_is_input[gi]} : `GQS_NOT_GPIO_DIR;
        end
    endgenerate

    // Readable views of engine state
    assign status_word   = {16'h0000, last_code_reg, 5'h00,
                            (state_reg == ST_EXEC), bad_reg, done_reg};
    assign settings_word = {11'h000, dac_value_reg, 5'h00, ref_src_reg,
                            ref_level_reg, 3'h0, clk_duty_reg, clk_div_reg};
    assign pins_word     = {12'h000, i_pin_is_input, 4'h0, i_pin_is_gpio,
                            4'h0, i_pin_level};

    // Read decode; unmapped addresses answer SLVERR with zero data
    always @* begin
        rd_data = 32'h0000_0000;
        rd_resp = `GQS_RESP_OKAY;
        if (i_s_axi_araddr[7:6] == `GQS_REGION_CMD) begin
            rd_data = cmd_mem[i_s_axi_araddr[5:2]];
        end else if (i_s_axi_araddr[7:6] == `GQS_REGION_REPLY) begin
            case (i_s_axi_araddr[5:2])
                4'h0: rd_data = reply_reg[31:0];
                4'h1: rd_data = reply_reg[63:32];
                4'h2: rd_data = {16'h0000, reply_reg[79:64]};
                default: rd_data = 32'h0000_0000;
            endcase
        end else begin
            case ({i_s_axi_araddr[7:2], 2'b00})
                `GQS_OFS_CTRL:     rd_data = 32'h0000_0000;
                `GQS_OFS_STATUS:   rd_data = status_word;
                `GQS_OFS_SETTINGS: rd_data = settings_word;
                `GQS_OFS_PINS:     rd_data = pins_word;
                default:                rd_resp = `GQS_RESP_SLVERR;
            endcase
        end
    end

    // Write address and data are captured separately; ready stays low until the
    // response is taken, so at most one write is in flight
    always @(posedge i_clk) begin
        if (i_rst) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `GQS_RESP_OKAY;
        end else if (i_ce) begin
            if (aw_hs) begin
                aw_addr_reg <= i_s_axi_awaddr;
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (w_hs) begin
                w_data_reg <= i_s_axi_wdata;
                w_strb_reg <= i_s_axi_wstrb;
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                if (wr_cmd | wr_ctrl | wr_status | wr_ro) begin
                    bresp_reg <= `GQS_RESP_OKAY;
                end else begin
                    bresp_reg <= `GQS_RESP_SLVERR;
                end
            end
            if (bvalid_reg & i_s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // Report buffer writes honour byte strobes
    always @(posedge i_clk) begin
        if (i_rst) begin
            for (k = 0; k < 16; k = k + 1) begin
                cmd_mem[k] <= 32'h0000_0000;
            end
        end else if (i_ce & do_write & wr_cmd) begin
            for (k = 0; k < 4; k = k + 1) begin
                if (w_strb_reg[k]) begin
                    cmd_mem[aw_addr_reg[5:2]][8*k +: 8] <= w_data_reg[8*k +: 8];
                end
            end
        end
    end

    // Read channel: data registered on the address handshake, held until taken
    always @(posedge i_clk) begin
        if (i_rst) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `GQS_RESP_OKAY;
        end else if (i_ce) begin
            if (ar_hs) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rd_data;
                rresp_reg   <= rd_resp;
            end else if (rvalid_reg & i_s_axi_rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // Go strobe from the control register; a go while executing is dropped
    always @(posedge i_clk) begin
        if (i_rst) begin
            go_reg <= 1'b0;
        end else if (i_ce) begin
            go_reg <= do_write & wr_ctrl & w_strb_reg[0] & w_data_reg[`GQS_CTRL_GO_BIT];
        end
    end

    // Engine: one cycle of execution per command; settings only ever live in
    // these flops, so only reset brings back the power-up values
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_reg     <= ST_IDLE;
            done_reg      <= 1'b0;
            bad_reg       <= 1'b0;
            last_code_reg <= 8'h00;
            reply_reg     <= 80'h0;
            clk_div_reg   <= DEF_CLK_DIV;
            clk_duty_reg  <= DEF_CLK_DUTY;
            ref_level_reg <= DEF_REF_LEVEL;
            ref_src_reg   <= DEF_REF_SRC;
            dac_value_reg <= DEF_DAC_VALUE;
        end else if (i_ce) begin
            // Software clear first so that a completing command wins
            if (clr_done) begin
                done_reg <= 1'b0;
            end
            if (clr_bad) begin
                bad_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (go_reg) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_reg     <= ST_IDLE;
                    done_reg      <= 1'b1;
                    last_code_reg <= cmd_code;
                    case (cmd_code)
                        `GQS_CMD_PIN_QUERY: begin
                            // Pins sampled in this cycle form bytes 2..9
                            reply_reg <= {pin_bytes, `GQS_REPLY_OK, cmd_code};
                        end
                        `GQS_CMD_SET_RUNTIME: begin
                            reply_reg <= {64'h0, `GQS_REPLY_OK, cmd_code};
                            if (set_clk[`GQS_LOAD_BIT]) begin
                                clk_duty_reg <= set_clk[`GQS_DUTY_HI:`GQS_DUTY_LO];
                                clk_div_reg  <= set_clk[`GQS_DIV_HI:0];
                            end
                            if (set_ref[`GQS_LOAD_BIT]) begin
                                ref_level_reg <=
                                    set_ref[`GQS_REF_LEVEL_HI:`GQS_REF_LEVEL_LO];
                                ref_src_reg   <= set_ref[`GQS_REF_SRC_BIT];
                            end
                            if (set_dac[`GQS_LOAD_BIT]) begin
                                dac_value_reg <= set_dac[`GQS_DAC_HI:0];
                            end
                        end
                        default: begin
                            // Unknown code: flag it and leave the last reply intact
                            bad_reg <= 1'b1;
                        end
                    endcase
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // All outputs come straight from flops
    assign o_s_axi_awready = awready_reg;
    assign o_s_axi_wready  = wready_reg;
    assign o_s_axi_bresp   = bresp_reg;
    assign o_s_axi_bvalid  = bvalid_reg;
    assign o_s_axi_arready = arready_reg;
    assign o_s_axi_rdata   = rdata_reg;
    assign o_s_axi_rresp   = rresp_reg;
    assign o_s_axi_rvalid  = rvalid_reg;
    assign o_clk_div       = clk_div_reg;
    assign o_clk_duty      = clk_duty_reg;
    assign o_int_ref_level = ref_level_reg;
    assign o_dac_ref_int   = ref_src_reg;
    assign o_dac_value     = dac_value_reg;
    assign o_busy          = state_reg[1];

endmodule // gqs_cmd_engine

// ===== design/gqs_defines.vh
// Constants for the pin-query and run-time settings command engine
`ifndef GQS_DEFINES_VH
`define GQS_DEFINES_VH

// Command codes carried in report byte 0, and the success code of reply byte 1
`define GQS_CMD_PIN_QUERY    8'h51
`define GQS_CMD_SET_RUNTIME  8'h60
`define GQS_REPLY_OK         8'h00

// Reply byte values for pins not assigned to GPIO use
`define GQS_NOT_GPIO_LEVEL   8'hee
`define GQS_NOT_GPIO_DIR     8'hef

// Field positions inside settings bytes
`define GQS_LOAD_BIT         7
`define GQS_DUTY_HI          4
`define GQS_DUTY_LO          3
`define GQS_DIV_HI           2
`define GQS_REF_LEVEL_HI     2
`define GQS_REF_LEVEL_LO     1
`define GQS_REF_SRC_BIT      0
`define GQS_DAC_HI           4

// Register byte offsets on the AXI4-Lite bus
`define GQS_OFS_CMD_BASE     8'h00
`define GQS_OFS_REPLY_BASE   8'h40
`define GQS_OFS_CTRL         8'h80
`define GQS_OFS_STATUS       8'h84
`define GQS_OFS_SETTINGS     8'h88
`define GQS_OFS_PINS         8'h8c

// Address region selects on byte address bits 7:6
`define GQS_REGION_CMD       2'b00
`define GQS_REGION_REPLY     2'b01

// Control and status bit positions
`define GQS_CTRL_GO_BIT      0
`define GQS_ST_DONE_BIT      0
`define GQS_ST_BAD_BIT       1
`define GQS_ST_BUSY_BIT      2

// AXI response codes
`define GQS_RESP_OKAY        2'b00
`define GQS_RESP_SLVERR      2'b10

`endif

// ===== design/gqs_settings_note.v
// Holds no logic: every setting lives in the command engine

// ===== sim/gqs_cmd_engine_sva.sv
// Checker for the command engine bus timing and settings outputs
`include "gqs_defines.vh"
module gqs_chk (
    input wire        i_clk,           // Clock
    input wire        i_rst,           // Reset, high
    input wire        i_s_axi_awvalid, // AW valid
    input wire        o_s_axi_awready, // AW ready
    input wire        i_s_axi_wvalid,  // W valid
    input wire        o_s_axi_wready,  // W ready
    input wire        o_s_axi_bvalid,  // B valid
    input wire        i_s_axi_arvalid, // AR valid
    input wire        o_s_axi_arready, // AR ready
    input wire [31:0] o_s_axi_rdata,   // Read data
    input wire [1:0]  o_s_axi_rresp,   // Read response
    input wire        o_s_axi_rvalid,  // R valid
    input wire        i_s_axi_rready,  // R ready
    input wire [2:0]  o_clk_div,       // Divider
    input wire [1:0]  o_clk_duty,      // Duty code
    input wire [1:0]  o_int_ref_level, // Reference level
    input wire        o_dac_ref_int,   // Reference source
    input wire [4:0]  o_dac_value,     // DAC value
    input wire        o_busy           // Executing
);
    timeunit 1ns;
    timeprecision 1ps;
    // All settings in one word, so a stray load anywhere is caught
    wire [12:0] sett = {o_clk_div, o_clk_duty, o_int_ref_level, o_dac_ref_int, o_dac_value};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Both halves of a write taken at one edge, and a read address taken
    sequence s_wr_both;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_rd_take;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    // Write is performed the edge after both halves are held, so bvalid shows two edges on
    a_wr_answer_time: assert property (s_wr_both |-> ##2 o_s_axi_bvalid)
        else $error("write response late");
    a_rd_answer_time: assert property (s_rd_take |=> o_s_axi_rvalid)
        else $error("read data late");
    a_rd_data_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data not held");
    a_wr_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write accepted while response pending");
    a_rd_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read accepted while data pending");
    a_busy_one_cycle: assert property (o_busy |=> !o_busy)
        else $error("busy longer than one cycle");
    a_sett_exec_only: assert property (!o_busy |=> $stable(sett))
        else $error("settings changed outside execution");
    a_reset_defaults: assert property ($fell(i_rst) |-> sett == 13'h0000)
        else $error("settings not at defaults after reset");
    a_bad_read_zero: assert property (o_s_axi_rvalid && o_s_axi_rresp == `GQS_RESP_SLVERR
        |-> o_s_axi_rdata == 32'h0000_0000) else $error("error read with data");
endmodule // gqs_chk

bind gqs_cmd_engine gqs_chk u_chk (
    .i_clk, .i_rst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bvalid, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
    .o_s_axi_rvalid, .i_s_axi_rready, .o_clk_div, .o_clk_duty, .o_int_ref_level,
    .o_dac_ref_int, .o_dac_value, .o_busy
);

// ===== sim/gqs_host_model.sv
// Host-side model: AXI4-Lite master that issues command reports
module gqs_host_model (
    input  wire         i_clk,               // Clock
    output logic [7:0]  o_awaddr  = 8'h00,   // Write address
    output logic        o_awvalid = 1'b0,    // AW valid
    input  wire         i_awready,           // AW ready
    output logic [31:0] o_wdata   = 32'h0,   // Write data
    output logic [3:0]  o_wstrb   = 4'hf,    // Whole words only
    output logic        o_wvalid  = 1'b0,    // W valid
    input  wire         i_wready,            // W ready
    input  wire [1:0]   i_bresp,             // Write response
    input  wire         i_bvalid,            // B valid
    output logic        o_bready  = 1'b1,    // Always ready: prompt side
    output logic [7:0]  o_araddr  = 8'h00,   // Read address
    output logic        o_arvalid = 1'b0,    // AR valid
    input  wire         i_arready,           // AR ready
    input  wire [31:0]  i_rdata,             // Read data
    input  wire [1:0]   i_rresp,             // Read response
    input  wire         i_rvalid,            // R valid
    output logic        o_rready  = 1'b0     // Raised late: slow side
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last_bresp;
    // A wait that runs out ends the run with a mismatch
    task automatic stall();
        tb_top.bad_count++;
        tb_top.report_and_stop();
    endtask
    // Handshakes are judged at the falling edge, where nothing moves
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw, w, b;
        n = 0;
        o_awaddr  <= a;
        o_wdata   <= d;
        o_awvalid <= 1'b1;
        o_wvalid  <= 1'b1;
        do begin
            @(negedge i_clk);
            aw = o_awvalid & i_awready;
            w = o_wvalid & i_wready;
            b = i_bvalid;
            last_bresp = i_bresp;
            @(posedge i_clk);
            if (aw) o_awvalid <= 1'b0;
            if (w) o_wvalid <= 1'b0;
            n++;
        end while (!b && n < 50);
        if (!b) stall();
    endtask
    // Ready follows valid by a cycle, so the slave must hold its data
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar, rv, hs;
        n = 0;
        o_araddr  <= a;
        o_arvalid <= 1'b1;
        do begin
            @(negedge i_clk);
            ar = o_arvalid & i_arready;
            rv = i_rvalid;
            hs = i_rvalid & o_rready;
            d = i_rdata;
            r = i_rresp;
            @(posedge i_clk);
            if (ar) o_arvalid <= 1'b0;
            o_rready <= rv & ~hs;
            n++;
        end while (!hs && n < 50);
        if (!hs) stall();
    endtask
    // Load the first report words, start, poll done, then clear status
    task automatic exec(input logic [31:0] w0, input logic [31:0] w1, output logic [31:0] st);
        logic [1:0] r;
        int n;
        wr(8'h00, w0);
        wr(8'h04, w1);
        wr(8'h80, 32'h0000_0001);
        n = 0;
        do begin
            rd(8'h84, st, r);
            n++;
        end while (!st[0] && n < 20);
        if (!st[0]) stall();
        wr(8'h84, 32'h0000_0003);
    endtask
endmodule // gqs_host_model

// ===== sim/tb_top.sv
// Testbench for the pin-query and run-time settings command engine
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [3:0]  pin_level = 4'h0, pin_is_gpio = 4'h0, pin_is_input = 4'h0;
    wire  [7:0]  awaddr, araddr;
    wire  [31:0] wdata, rdata;
    wire  [3:0]  wstrb;
    wire  [1:0]  bresp, rresp, clk_duty, ref_level;
    wire         awvalid, awready, wvalid, wready, bvalid, bready;
    wire         arvalid, arready, rvalid, rready, ref_int, busy;
    wire  [2:0]  clk_div;
    wire  [4:0]  dac_value;
    logic [2:0]  e_div;
    logic [1:0]  e_duty, e_lvl;
    logic        e_src;
    logic [4:0]  e_dac;
    int          bad_count = 0;
    int          check_count = 0;

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    gqs_cmd_engine dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_pin_level(pin_level),
        .i_pin_is_gpio(pin_is_gpio), .i_pin_is_input(pin_is_input), .o_clk_div(clk_div),
        .o_clk_duty(clk_duty), .o_int_ref_level(ref_level), .o_dac_ref_int(ref_int),
        .o_dac_value(dac_value), .o_busy(busy)
    );
    gqs_host_model host (
        .i_clk(i_clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
        .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
        .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
        .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
        .i_rvalid(rvalid), .o_rready(rready)
    );

    task automatic report_and_stop();
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Expected level and direction bytes of one pin
    function automatic logic [15:0] pair(input logic g, input logic l, input logic d);
        return g ? {7'h0, d, 7'h0, l} : 16'hefee;
    endfunction
    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic chk_sett();
        chk("clk div", e_div, clk_div);
        chk("clk duty", e_duty, clk_duty);
        chk("ref level", e_lvl, ref_level);
        chk("ref source", e_src, ref_int);
        chk("dac value", e_dac, dac_value);
    endtask
    // Settings return to the power-up values after every reset
    task automatic t_defaults();
        {e_div, e_duty, e_lvl, e_src, e_dac} = 13'h0000;
        chk_sett();
    endtask
    // Query with junk in the ignored bytes; reply built per pin
    task automatic t_query(input logic [3:0] g, input logic [3:0] l, input logic [3:0] d);
        logic [31:0] st, w0, w1, w2;
        logic [1:0]  r;
        pin_is_gpio  <= g;
        pin_level    <= l;
        pin_is_input <= d;
        host.exec(32'h5a3c_c351, 32'hffff_ffff, st);
        host.rd(8'h40, w0, r);
        host.rd(8'h44, w1, r);
        host.rd(8'h48, w2, r);
        chk("reply word0", {pair(g[0], l[0], d[0]), 16'h0051}, w0);
        chk("reply word1", {pair(g[2], l[2], d[2]), pair(g[1], l[1], d[1])}, w1);
        chk("reply word2", {16'h0, pair(g[3], l[3], d[3])}, {16'h0, w2[15:0]});
    endtask
    // Loud don't-care bits in bytes 1-4; values land only when ld is set
    task automatic t_settings(input logic ld, input logic [2:0] dv, input logic [1:0] du,
                              input logic [1:0] lv, input logic sr, input logic [4:0] da);
        logic [31:0] st;
        logic [1:0]  r;
        host.exec({ld, 4'hf, lv, sr, ld, 2'b11, du, dv, 8'hc3, 8'h60},
                  {24'h0, ld, 2'b11, da}, st);
        if (ld) {e_div, e_duty, e_lvl, e_src, e_dac} = {dv, du, lv, sr, da};
        chk_sett();
        host.rd(8'h88, st, r);
        chk("settings word", {11'h0, e_dac, 5'h0, e_src, e_lvl, 3'h0, e_duty, e_div}, st);
    endtask
    // Unmapped places answer with an error; unknown code is flagged
    task automatic t_odd();
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(8'h90, d, r);
        chk("unmapped read resp", 2'b10, r);
        host.wr(8'h94, 32'hffff_ffff);
        chk("unmapped write resp", 2'b10, host.last_bresp);
        host.exec(32'h0000_0052, 32'h0, d);
        chk("bad code flag", 1'b1, d[1]);
        chk("last code", 8'h52, d[15:8]);
        chk_sett();
    endtask

    // Main sequence
    initial begin
        do_reset();
        t_defaults();
        t_query(4'hf, 4'h5, 4'h3);
        t_query(4'h0, 4'hf, 4'hf);
        t_query(4'ha, 4'hf, 4'hc);
        for (int i = 0; i < 4; i++) begin
            t_settings(1'b1, 3'(2 * i + 1), 2'(i), 2'(3 - i), 1'(i), 5'(7 * i + 3));
        end
        t_settings(1'b0, 3'h2, 2'h1, 2'h2, 1'b0, 5'h0a);
        t_odd();
        do_reset();
        t_defaults();
        report_and_stop();
    end
endmodule // tb_top
